// ---- verilog/spm_pkg.sv ----
// Constants for the sector guard map command block
package spm_pkg;
	localparam int MAP_BYTES = 8;
	localparam logic [63:0] MAP_RESET = 64'h0000_0000_0000_0000;
	localparam logic [7:0] BYTE_ERASED = 8'hFF;
	localparam logic [7:0] OP_PREFIX0 = 8'h3D;
	localparam logic [7:0] OP_PREFIX1 = 8'h2A;
	localparam logic [7:0] OP_PREFIX2 = 8'h7F;
	localparam logic [7:0] OP_MAP_ERASE = 8'hCF;
	localparam logic [7:0] OP_MAP_PROG = 8'hFC;
	localparam logic [7:0] OP_MAP_READ = 8'h32;
	localparam int READ_DUMMY_BYTES = 3;
	localparam int SUB_LOW_HI = 7;
	localparam int SUB_LOW_LO = 6;
	localparam int SUB_HIGH_HI = 5;
	localparam int SUB_HIGH_LO = 4;
	// Timings in microseconds, cycles at 200 MHz
	localparam int CLK_MHZ = 200;
	localparam int MAP_ERASE_TIME_US = 50;
	localparam int PROGRAM_CYCLE_TIME_US = 50;
	localparam int MAP_ERASE_CYCLES = MAP_ERASE_TIME_US * CLK_MHZ;
	localparam int PROGRAM_CYCLE_CYCLES = PROGRAM_CYCLE_TIME_US * CLK_MHZ;
	localparam int BUF_BYTES = 256;
	typedef enum logic [5:0] {
		SPM_IDLE = 6'b00_0001,
		SPM_OPC = 6'b00_0010,
		SPM_PDATA = 6'b00_0100,
		SPM_RDUMMY = 6'b00_1000,
		SPM_RDATA = 6'b01_0000,
		SPM_SKIP = 6'b10_0000
	} spm_state_t;
endpackage

// ---- verilog/spm_timer.sv ----
// Down counter timing self-timed map operations
`timescale 1ns/100ps
module spm_timer (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic start_i,
	input wire logic [31:0] cycles_i,
	output logic busy_o,
	output logic done_o
);
	logic [31:0] count;

	// Load on start, raise done on the last count
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			count <= 32'h0000_0000;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= 1'b0;
			if (start_i && !busy_o)
			begin
				count <= cycles_i - 32'h0000_0001;
				busy_o <= 1'b1;
			end
			else if (busy_o)
			begin
				if (count == 32'h0000_0000)
				begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
				else
					count <= count - 32'h0000_0001;
			end
		end
	end
endmodule // spm_timer

// ---- verilog/spm_map.sv ----
// What this block does
// - Eight byte map, one per sector
// - Sectors 1-7: FFH guarded, 00H unguarded
// - Sector 0 bit pairs guard two subsectors
// - Erase opcode 3D 2A 7F CF, CS release
// - Erase self-timed, busy throughout
// - Erase accepted regardless of protection enable
// - Program opcode then eight bytes, sector order
// - Program starts on CS release, busy
// - Ninth byte wraps to position zero
// - Program accepted regardless of protection enable
// - Program overwrites data buffer one
// - Read opcode 32H, three dummies, eight bytes
// - Past eighth byte output 00H, no wrap
// - CS release ends read, output floats
// - Shipped map is all zeros
// - Map applies only while protection enabled
// - Write protect blocks map erase/program
`timescale 1ns/100ps
module spm_map (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic wp_n_i,
	input wire logic prot_en_i,
	output logic so_o,
	output logic so_oe_o,
	output logic busy_o,
	output logic [7:0] sector_guard_o,
	output logic subsector_low_guard_o,
	output logic subsector_high_guard_o,
	output logic [7:0] buf1_wr_addr_o,
	output logic [7:0] buf1_wr_data_o,
	output logic buf1_wr_en_o
);
	import spm_pkg::*;

	spm_state_t state;
	logic [63:0] sector_guard_map;
	logic [63:0] staged;
	logic [7:0] shift_in;
	logic [2:0] bit_cnt;
	logic [1:0] opc_idx;
	logic [2:0] byte_idx;
	logic [3:0] rd_idx;
	logic [7:0] out_byte;
	logic is_prog;
	logic opc_ok;
	logic sck_d;
	logic cs_d;
	logic [7:0] got;
	logic byte_done;
	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic start_erase;
	logic start_prog;
	logic pend_erase;
	logic t_busy;
	logic t_done;
	logic [31:0] t_cycles;

	// Byte at an index of the map
	function automatic logic [7:0] map_byte(input logic [63:0] m, input logic [2:0] i);
		map_byte = m[{i, 3'b000} +: 8];
	endfunction

	assign sck_rise = sck_i && !sck_d && !cs_n_i;
	assign sck_fall = !sck_i && sck_d && !cs_n_i;
	assign cs_rise = cs_n_i && !cs_d;
	assign got = {shift_in[6:0], si_i};
	assign byte_done = sck_rise && (bit_cnt == 3'd7);

	// Edge history of link pins
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			sck_d <= 1'b0;
			cs_d <= 1'b1;
		end
		else
		begin
			sck_d <= sck_i;
			cs_d <= cs_n_i;
		end
	end

	// Bit shifter, MSB first
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			shift_in <= 8'h00;
			bit_cnt <= 3'd0;
		end
		else if (cs_n_i)
			bit_cnt <= 3'd0;
		else if (sck_rise)
		begin
			shift_in <= got;
			bit_cnt <= bit_cnt + 3'd1;
		end
	end

	// Command decoder
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state <= SPM_IDLE;
			opc_idx <= 2'd0;
			byte_idx <= 3'd0;
			rd_idx <= 4'd0;
			is_prog <= 1'b0;
			opc_ok <= 1'b0;
			staged <= MAP_RESET;
		end
		else if (cs_n_i)
		begin
			state <= SPM_IDLE;
			opc_idx <= 2'd0;
			opc_ok <= 1'b0; // Frame over, so a later release cannot relaunch
		end
		else if (byte_done)
		begin
			unique case (state)
				SPM_IDLE:
				begin
					if (got == OP_MAP_READ)
					begin
						state <= SPM_RDUMMY;
						opc_idx <= 2'd1;
					end
					else if (got == OP_PREFIX0)
					begin
						state <= SPM_OPC;
						opc_idx <= 2'd1;
						opc_ok <= 1'b0;
					end
					else
						state <= SPM_SKIP;
				end
				SPM_OPC:
				begin
					opc_idx <= opc_idx + 2'd1;
					if (opc_idx == 2'd1 && got != OP_PREFIX1)
						state <= SPM_SKIP;
					else if (opc_idx == 2'd2 && got != OP_PREFIX2)
						state <= SPM_SKIP;
					else if (opc_idx == 2'd3)
					begin
						is_prog <= (got == OP_MAP_PROG);
						opc_ok <= (got == OP_MAP_ERASE) || (got == OP_MAP_PROG);
						byte_idx <= 3'd0;
						staged <= sector_guard_map;
						state <= (got == OP_MAP_PROG) ? SPM_PDATA : SPM_SKIP;
					end
				end
				SPM_PDATA:
				begin
					staged[{byte_idx, 3'b000} +: 8] <= got;
					byte_idx <= byte_idx + 3'd1;
				end
				SPM_RDUMMY:
				begin
					opc_idx <= opc_idx + 2'd1;
					rd_idx <= 4'd0;
					if (opc_idx == 2'(READ_DUMMY_BYTES))
						state <= SPM_RDATA;
				end
				SPM_RDATA:
					rd_idx <= (rd_idx == 4'(MAP_BYTES)) ? rd_idx : rd_idx + 4'd1;
				SPM_SKIP:
					state <= SPM_SKIP;
			endcase
		end
	end

	assign start_erase = cs_rise && opc_ok && !is_prog && wp_n_i && !t_busy;
	assign start_prog = cs_rise && opc_ok && is_prog && wp_n_i && !t_busy;

	assign t_cycles = start_prog ? 32'(PROGRAM_CYCLE_CYCLES - 1) : 32'(MAP_ERASE_CYCLES - 1); // Launch cycle counts too

	spm_timer u_timer (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.start_i(start_erase || start_prog),
		.cycles_i(t_cycles),
		.busy_o(t_busy),
		.done_o(t_done)
	);

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			sector_guard_map <= MAP_RESET;
			pend_erase <= 1'b0;
		end
		else
		begin
			if (start_erase || start_prog)
				pend_erase <= start_erase;
			if (t_done)
			begin
				if (pend_erase)
					sector_guard_map <= {MAP_BYTES{BYTE_ERASED}};
				else
					sector_guard_map <= sector_guard_map & staged;
			end
		end
	end

	// Status busy flag
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			busy_o <= 1'b0;
		else
			busy_o <= t_busy || start_erase || start_prog;
	end

	// mirror program data bytes into buffer one
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			buf1_wr_en_o <= 1'b0;
			buf1_wr_addr_o <= 8'h00;
			buf1_wr_data_o <= 8'h00;
		end
		else
		begin
			buf1_wr_en_o <= byte_done && state == SPM_PDATA;
			buf1_wr_addr_o <= {5'd0, byte_idx};
			buf1_wr_data_o <= got;
		end
	end

	// guard decode, ignores sector 0 low bits
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			sector_guard_o <= 8'h00;
			subsector_low_guard_o <= 1'b0;
			subsector_high_guard_o <= 1'b0;
		end
		else
		begin
			for (int s = 1; s < MAP_BYTES; s++)
				sector_guard_o[s] <= prot_en_i && (map_byte(sector_guard_map, 3'(s)) == BYTE_ERASED);
			subsector_low_guard_o <= prot_en_i && (&sector_guard_map[SUB_LOW_HI:SUB_LOW_LO]);
			subsector_high_guard_o <= prot_en_i && (&sector_guard_map[SUB_HIGH_HI:SUB_HIGH_LO]);
			sector_guard_o[0] <= prot_en_i && (&sector_guard_map[SUB_LOW_HI:SUB_HIGH_LO]);
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			so_o <= 1'b0;
			so_oe_o <= 1'b0;
			out_byte <= 8'h00;
		end
		else if (cs_n_i)
			so_oe_o <= 1'b0;
		else if (state == SPM_RDATA && sck_fall)
		begin
			so_oe_o <= 1'b1;
			if (bit_cnt == 3'd0)
			begin
				out_byte <= (rd_idx < 4'(MAP_BYTES)) ? map_byte(sector_guard_map, rd_idx[2:0]) : 8'h00;
				so_o <= (rd_idx < 4'(MAP_BYTES)) && sector_guard_map[{rd_idx[2:0], 3'b111}];
			end
			else
				so_o <= out_byte[3'd7 - bit_cnt];
		end
	end
endmodule // spm_map

// ---- dv/spm_map_monitor.sv ----
// Port-level assertions for the sector guard map block
`timescale 1ns/100ps
module spm_map_monitor import spm_pkg::*; (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic wp_n_i,
	input wire logic prot_en_i,
	input wire logic so_o,
	input wire logic so_oe_o,
	input wire logic busy_o,
	input wire logic [7:0] sector_guard_o,
	input wire logic subsector_low_guard_o,
	input wire logic subsector_high_guard_o,
	input wire logic [7:0] buf1_wr_addr_o,
	input wire logic [7:0] buf1_wr_data_o,
	input wire logic buf1_wr_en_o
);
	int busy_len;
	// Length of the current busy stretch
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			busy_len <= 0;
		else if (busy_o)
			busy_len <= busy_len + 1;
		else
			busy_len <= 0;
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	property p_busy_hold; $rose(busy_o) |-> busy_o [*8]; endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
	property p_busy_max; busy_o |-> busy_len < PROGRAM_CYCLE_CYCLES; endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy too long");
	property p_busy_min; $fell(busy_o) |-> busy_len >= MAP_ERASE_CYCLES - 1; endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy too short");
	property p_busy_cs; $rose(busy_o) |-> $past(cs_n_i) && !$past(cs_n_i, 2); endproperty
	a_busy_cs: assert property (p_busy_cs) else $error("busy without select release");
	property p_busy_wp; $rose(busy_o) |-> $past(wp_n_i); endproperty
	a_busy_wp: assert property (p_busy_wp) else $error("busy while write protected");
	property p_oe_off; cs_n_i [*3] |-> !so_oe_o; endproperty
	a_oe_off: assert property (p_oe_off) else $error("output enabled while deselected");
	property p_wr_addr; buf1_wr_en_o |-> buf1_wr_addr_o < MAP_BYTES; endproperty
	a_wr_addr: assert property (p_wr_addr) else $error("buffer index past map");
	property p_wr_cs; buf1_wr_en_o |-> !busy_o && !$past(cs_n_i); endproperty
	a_wr_cs: assert property (p_wr_cs) else $error("buffer write outside frame");
	property p_sub_pair; sector_guard_o[0] |-> subsector_low_guard_o && subsector_high_guard_o; endproperty
	a_sub_pair: assert property (p_sub_pair) else $error("sector zero guard mismatch");
	property p_guard_en; sector_guard_o != 8'h00 |-> $past(prot_en_i); endproperty
	a_guard_en: assert property (p_guard_en) else $error("guard without protection");
	property p_reset_map; $past(sys_rst_i) |-> sector_guard_o == 8'h00 && !busy_o; endproperty
	a_reset_map: assert property (p_reset_map) else $error("guard set after reset");
endmodule // spm_map_monitor
bind spm_map spm_map_monitor u_mon (.*);

// ---- dv/spm_host.sv ----
// Host serial master model issuing map commands
`timescale 1ns/100ps
module spm_host (
	input wire logic clock_i,
	input wire logic so_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic si_o
);
	initial
	begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
	end
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int b = 7; b >= 0; b--)
		begin
			@(posedge clock_i);
			si_o <= tx[b];
			cs_n_o <= 1'b0;
			repeat (3) @(posedge clock_i);
			#1 rx[b] = so_i;
			@(posedge clock_i);
			sck_o <= 1'b1;
			repeat (4) @(posedge clock_i);
			sck_o <= 1'b0;
		end
	endtask
	task automatic stop();
		repeat (3) @(posedge clock_i);
		cs_n_o <= 1'b1;
		si_o <= ~si_o;
		repeat (3) @(posedge clock_i);
	endtask
endmodule // spm_host

// ---- dv/tb_spm_map.sv ----
// Self-checking bench for the sector guard map block
`timescale 1ns/100ps
module tb_spm_map;
	import spm_pkg::*;
	logic clock_i, sys_rst_i, wp_n_i, prot_en_i, cs_n, sck, si, so_o, so_oe_o, busy_o, sub_lo, sub_hi, wr_en;
	logic [7:0] guard, wr_addr, wr_data, rx;
	logic [7:0] buf_seen [8];
	logic [63:0] m;
	int error_cnt = 0;
	int total_checks = 0;
	int wr_cnt = 0;
	spm_map uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .wp_n_i(wp_n_i),
		.prot_en_i(prot_en_i), .so_o(so_o), .so_oe_o(so_oe_o), .busy_o(busy_o), .sector_guard_o(guard),
		.subsector_low_guard_o(sub_lo), .subsector_high_guard_o(sub_hi), .buf1_wr_addr_o(wr_addr),
		.buf1_wr_data_o(wr_data), .buf1_wr_en_o(wr_en));
	spm_host host (.clock_i(clock_i), .so_i(so_oe_o ? so_o : !so_o), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
	// Clock
	initial
	begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	// Record buffer writes
	always @(posedge clock_i)
	begin
		if (wr_en === 1'b1)
		begin
			buf_seen[wr_addr[2:0]] <= wr_data;
			wr_cnt <= wr_cnt + 1;
		end
	end
	function automatic logic [7:0] guard_exp(input logic [63:0] v, input logic pe);
		guard_exp[0] = pe & (v[7:4] == 4'hF);
		for (int i = 1; i < 8; i++)
			guard_exp[i] = pe & (v[8*i +: 8] == 8'hFF);
	endfunction
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmd4(input logic [7:0] op);
		logic [31:0] seq = {OP_PREFIX0, OP_PREFIX1, OP_PREFIX2, op};
		for (int k = 3; k >= 0; k--)
			host.xfer(seq[8*k +: 8], rx);
	endtask
	task automatic wait_idle();
		int n = 0;
		while (busy_o !== 1'b0 && n < MAP_ERASE_CYCLES + 200)
		begin
			@(posedge clock_i);
			n++;
		end
		if (busy_o !== 1'b0)
		begin
			error_cnt++;
			conclude();
		end
	endtask
	task automatic read_map(input logic [63:0] v);
		host.xfer(OP_MAP_READ, rx);
		repeat (READ_DUMMY_BYTES) host.xfer(8'h00, rx);
		for (int i = 0; i < 9; i++)
		begin
			host.xfer(8'h00, rx);
			check("read byte", rx, (i < 8) ? v[8*i +: 8] : 8'h00);
		end
		check("oe", so_oe_o, 1'b1);
		host.stop();
		check("oe off", so_oe_o, 1'b0);
		check("guard", guard, guard_exp(v, prot_en_i));
		check("sub", {sub_lo, sub_hi}, {prot_en_i & (v[7:6] == 2'b11), prot_en_i & (v[5:4] == 2'b11)});
	endtask
	// Main sequence
	initial
	begin
		sys_rst_i = 1'b1;
		wp_n_i = 1'b1;
		prot_en_i = 1'b0;
		void'($urandom(32'h8022_531d));
		repeat (4) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
		read_map(MAP_RESET);
		$display("test reset done");
		// Short opcode, wrong opcode, write protected erase
		host.xfer(OP_PREFIX0, rx);
		host.xfer(OP_PREFIX1, rx);
		host.stop();
		check("busy short", busy_o, 1'b0);
		cmd4(8'h00);
		host.stop();
		check("busy wrong", busy_o, 1'b0);
		wp_n_i <= 1'b0;
		cmd4(OP_MAP_ERASE);
		host.stop();
		check("busy wp", busy_o, 1'b0);
		wp_n_i <= 1'b1;
		read_map(MAP_RESET);
		$display("test refusals done");
		// erase then program, two rounds only
		for (int r = 0; r < 2; r++)
		begin
			prot_en_i <= 1'(r);
			cmd4(OP_MAP_ERASE);
			host.stop();
			check("busy erase", busy_o, 1'b1);
			wait_idle();
			read_map({8{BYTE_ERASED}});
			m[7:0] = {(r == 1) ? 4'hF : {{2{1'($urandom)}}, {2{1'($urandom)}}}, 4'($urandom)};
			for (int i = 1; i < 8; i++)
				m[8*i +: 8] = {8{1'($urandom)}};
			wr_cnt = 0;
			cmd4(OP_MAP_PROG);
			host.xfer(8'($urandom), rx);
			for (int i = 1; i < 9; i++)
				host.xfer(m[8*(i % 8) +: 8], rx);
			host.stop();
			check("busy prog", busy_o, 1'b1);
			check("buf writes", wr_cnt, 9);
			check("buf wrap", buf_seen[0], m[7:0]);
			wait_idle();
			read_map(m);
			$display("test round %0d done", r);
		end
		conclude();
	end
endmodule // tb_spm_map
